// File: scec_map.svh
// register map, field positions, reset values and timing counts
`ifndef SCEC_MAP_SVH
`define SCEC_MAP_SVH
// ***************************************
// register word indices
// ***************************************
`define SCEC_IDX_BUF  14'h1200
`define SCEC_IDX_CTL  14'h1201
`define SCEC_IDX_MOD  14'h1202
`define SCEC_IDX_DIV  14'h1206
`define SCEC_IDX_IST  14'h1207
`define SCEC_IDX_IMSK 14'h1208
// ***************************************
// reset values
// ***************************************
`define SCEC_MOD_RST  8'h00
`define SCEC_DIV_RST  16'h0001
// ***************************************
// control register fields
// ***************************************
`define SCEC_CTL_IOC   0
`define SCEC_CTL_SCLKS 1
`define SCEC_CTL_PE    5
`define SCEC_CTL_EVEN  6
// ***************************************
// interrupt status fields
// ***************************************
`define SCEC_IRQ_RX  0
`define SCEC_IRQ_TX  1
`define SCEC_IRQ_OVR 2
`define SCEC_IRQ_PAR 3
`define SCEC_IRQ_FRM 4
// ***************************************
// transfer mode and clock source codes
// ***************************************
`define SCEC_SM_IO  2'h0
`define SCEC_SM_7   2'h1
`define SCEC_SM_8   2'h2
`define SCEC_SM_9   2'h3
`define SCEC_SC_TMR 2'h0
`define SCEC_SC_BRG 2'h1
`define SCEC_SC_FIO 2'h2
`define SCEC_SC_EXT 2'h3
// ***************************************
// timing counts in sampling clocks, and the last io bit count in shift clock edges
// ***************************************
`define SCEC_SMP_A  4'h6
`define SCEC_SMP_B  4'h7
`define SCEC_SMP_C  4'h8
`define SCEC_TX_DIV 4'hf
`define SCEC_IO_LAST 3'h7
`endif

// File: scec_pkg.sv
// types shared by the serial channel event timing block
package scec_pkg;
  typedef struct packed {
    logic       tx_ninth_bit;
    logic       handshake_enable;
    logic       receive_enable;
    logic       wakeup_enable;
    logic [1:0] transfer_mode;
    logic [1:0] clock_source;
  } scec_mode_t;
  typedef struct packed {
    logic tmr;
    logic cts_n;
    logic sclk;
    logic rxd;
  } scec_pins_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} scec_rx_st_t;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} scec_tx_st_t;
endpackage

// File: scec_sync.sv
// three-flop synchroniser, output moves once stages two and three agree
`timescale 1ns/1ns
module scec_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  wire  [W-1:0] agree = ~(s2_q ^ s3_q);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
      q_o  <= RST;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q_o  <= (agree & s3_q) | (~agree & q_o);
    end
  end
endmodule

// File: scec_tick.sv
// programmable divider giving one pulse every div_i+1 clocks
`timescale 1ns/1ns
module scec_tick #(
  parameter int W = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] div_i,
  output logic              tick_o
);
  logic [W-1:0] cnt_q;
  wire          wrap = cnt_q >= div_i;

  generate
    if (W < 2 || W > 24) begin : g_bad
      $error("scec_tick width out of range");
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q  <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt_q  <= wrap ? '0 : cnt_q + 1'b1;
      tick_o <= wrap;
    end
  end
endmodule

// File: scec_top.sv
// serial channel with frame-accurate interrupt and error timing
//
// Behaviour
// [RULE_01] rx interrupt at last data, parity or stop
// [RULE_02] framing error at stop bit centre
// [RULE_03] parity error: none 9-bit, parity or stop
// [RULE_04] overrun raised where rx interrupt is raised
// [RULE_05] software waits one bit before framing check
// [RULE_06] events may trail bit centre at speed
// [RULE_07] tx interrupt just before stop bit
// [RULE_08] io internal clock: tx irq after last bit
// [RULE_09] io external clock: tx irq after last edge
// [RULE_10] io rx interrupt when byte reaches buffer
// [RULE_11] clock source field only for uart mode
// [RULE_12] mode field: io, 7, 8, 9 bit uart
// [RULE_13] source field: timer, baud, io clock, pin
// [RULE_14] majority of samples 7, 8, 9 of 16
// [RULE_15] wakeup: 9-bit rx irq only if bit8 set
// [RULE_16] clear-to-send high holds next frame
// [RULE_17] control read clears all error flags
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ns
`include "scec_map.svh"
module scec_top
  import scec_pkg::*;
#(
  parameter int DIV_W = 16
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // avalon-mm slave
  input  wire logic [15:0] address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  input  wire logic [3:0]  byteenable_i,
  output logic      [31:0] readdata_o,
  output logic             waitrequest_o,
  // serial pins
  input  wire logic        rxd_i,
  output logic             txd_o,
  input  wire logic        serial_clock_pin_i,
  output logic             serial_clock_pin_o,
  output logic             serial_clock_pin_oe_o,
  input  wire logic        clear_to_send_input_n_i,
  input  wire logic        timer_a0_trig_i,
  // interrupts
  output logic             receive_interrupt_o,
  output logic             transmit_interrupt_o,
  output logic             irq_o
);
  generate
    if (DIV_W < 9 || DIV_W > 16) begin : g_bad
      $error("DIV_W must lie in 9..16");
    end
  endgenerate

  // ***************************************
  // avalon decode
  // ***************************************
  logic        ack_q;
  wire         req      = read_i | write_i;
  wire  [13:0] idx      = address_i[15:2];
  wire         hit_buf  = idx == `SCEC_IDX_BUF;
  wire         hit_ctl  = idx == `SCEC_IDX_CTL;
  wire         hit_mod  = idx == `SCEC_IDX_MOD;
  wire         hit_div  = idx == `SCEC_IDX_DIV;
  wire         hit_ist  = idx == `SCEC_IDX_IST;
  wire         hit_imsk = idx == `SCEC_IDX_IMSK;
  wire         wr_acc   = write_i & ack_q;
  wire         wr0      = wr_acc & byteenable_i[0];
  wire         wr1      = wr_acc & byteenable_i[1];
  // read side effects fire on the capture edge so a flag set there survives
  wire         rd_cap   = read_i & ~ack_q;
  assign waitrequest_o = req & ~ack_q;

  // ***************************************
  // registers
  // ***************************************
  scec_mode_t       mode_q;
  logic             ioc_q;
  logic             sclks_q;
  logic             pe_q;
  logic             even_q;
  logic             rb8_q;
  logic [2:0]       err_q;
  logic [DIV_W-1:0] div_q;
  logic [4:0]       ist_q;
  logic [4:0]       imsk_q;
  logic [7:0]       rx_buf_q;
  logic             buf_full_q;
  logic [7:0]       tx_buf_q;
  logic             tx_full_q;

  wire [1:0] sm      = mode_q.transfer_mode;
  wire       uart    = sm != `SCEC_SM_IO; // RULE_12
  wire       m9      = sm == `SCEC_SM_9;
  wire       m8      = sm == `SCEC_SM_8;
  wire       par_on  = pe_q & ~m9;
  wire [3:0] nb      = m9 ? 4'h9 : (m8 ? 4'h8 : 4'h7) + {3'h0, par_on};
  wire       early   = m9 | (m8 & par_on);
  wire [7:0] ctl_rd  = {rb8_q, even_q, pe_q, err_q, sclks_q, ioc_q};

  // ***************************************
  // pins and sampling clock
  // ***************************************
  scec_pins_t pins_raw;
  scec_pins_t pins_s;
  scec_pins_t pins_p_q;
  logic       brg_tick;
  wire        io_act;
  assign pins_raw = '{tmr: timer_a0_trig_i, cts_n: clear_to_send_input_n_i,
                      sclk: serial_clock_pin_i, rxd: rxd_i};

  // pin latency is why events trail the true bit centre at high rates
  scec_sync #(.W(4), .RST(4'h7)) u_sync ( // RULE_06
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    (pins_raw),
    .q_o    (pins_s)
  );

  scec_tick #(.W(DIV_W)) u_brg (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .div_i  (div_q),
    .tick_o (brg_tick)
  );

  wire sclk_rise = pins_s.sclk & ~pins_p_q.sclk;
  wire sclk_fall = ~pins_s.sclk & pins_p_q.sclk;
  wire tmr_rise  = pins_s.tmr & ~pins_p_q.tmr;
  // RULE_13
  wire smp_tick  = mode_q.clock_source == `SCEC_SC_TMR ? tmr_rise :
                   mode_q.clock_source == `SCEC_SC_BRG ? brg_tick :
                   mode_q.clock_source == `SCEC_SC_FIO ? 1'b1 : sclk_rise;

  // reset to the synchroniser idle levels so release shows no false edge
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pins_p_q <= 4'h7;
    end else begin
      pins_p_q <= pins_s;
    end
  end

  // ***************************************
  // uart receive timing
  // ***************************************
  scec_rx_st_t rx_st_q;
  logic [3:0]  rx_cnt_q;
  logic [3:0]  rx_bit_q;
  logic [1:0]  smp_q;
  logic [8:0]  rx_sh_q;

  wire       centre  = uart & smp_tick & (rx_st_q != RX_IDLE) & (rx_cnt_q == `SCEC_SMP_C);
  wire       maj     = (smp_q[0] & smp_q[1]) | (pins_s.rxd & (smp_q[0] | smp_q[1])); // RULE_14
  wire       rx_last = rx_bit_q == nb - 4'h1;
  wire [8:0] src     = rx_st_q == RX_DATA ? {maj, rx_sh_q[8:1]} : rx_sh_q;
  wire [3:0] rshift  = 4'h9 - nb;
  wire [8:0] u_word  = src >> rshift;
  // RULE_01 RULE_04
  wire       rx_xfer = centre & (early ? (rx_st_q == RX_DATA) & rx_last
                                       : rx_st_q == RX_STOP);
  wire       wake_ok = ~(mode_q.wakeup_enable & m9) | u_word[8]; // RULE_15

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_st_q  <= RX_IDLE;
      rx_cnt_q <= 4'h0;
      rx_bit_q <= 4'h0;
      smp_q    <= 2'h3;
      rx_sh_q  <= 9'h000;
    end else if (!uart) begin
      rx_st_q <= RX_IDLE;
      if (io_act) begin
        rx_sh_q <= {pins_s.rxd, rx_sh_q[8:1]};
      end
    end else if (smp_tick) begin
      rx_cnt_q <= rx_cnt_q + 4'h1;
      if (rx_cnt_q == `SCEC_SMP_A) smp_q[0] <= pins_s.rxd; // RULE_14
      if (rx_cnt_q == `SCEC_SMP_B) smp_q[1] <= pins_s.rxd;
      case (rx_st_q)
        RX_IDLE: begin
          rx_cnt_q <= 4'h1;
          if (mode_q.receive_enable && !pins_s.rxd) rx_st_q <= RX_START;
        end
        RX_START: if (centre) begin
          rx_st_q  <= maj ? RX_IDLE : RX_DATA;
          rx_bit_q <= 4'h0;
        end
        RX_DATA: if (centre) begin
          rx_sh_q  <= {maj, rx_sh_q[8:1]};
          rx_bit_q <= rx_bit_q + 4'h1;
          if (rx_last) rx_st_q <= RX_STOP;
        end
        RX_STOP: if (centre) rx_st_q <= RX_IDLE;
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // ***************************************
  // io interface shift engine
  // ***************************************
  logic       io_run_q;
  logic       io_tx_q;
  logic [2:0] io_cnt_q;
  logic       sclk_q;
  wire        io_rise  = ioc_q ? sclk_rise : brg_tick & io_run_q & ~sclk_q;
  wire        io_fall  = ioc_q ? sclk_fall : brg_tick & io_run_q & sclk_q;
  // RULE_11
  assign io_act = ~uart & io_run_q & (sclks_q ? io_fall : io_rise);
  wire        io_last  = io_act & (io_cnt_q == `SCEC_IO_LAST);
  wire        io_go    = ~uart & ~io_run_q &
                         (tx_full_q | (mode_q.receive_enable & ~buf_full_q));

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      io_run_q <= 1'b0;
      io_tx_q  <= 1'b0;
      io_cnt_q <= 3'h0;
      sclk_q   <= 1'b1;
    end else begin
      if (uart) io_run_q <= 1'b0;
      else if (io_go) begin
        io_run_q <= 1'b1;
        io_tx_q  <= tx_full_q;
        io_cnt_q <= 3'h0;
      end else if (io_act) begin
        io_cnt_q <= io_cnt_q + 3'h1;
        if (io_last) io_run_q <= 1'b0;
      end
      if (io_run_q && !ioc_q && brg_tick) sclk_q <= ~sclk_q;
    end
  end

  // ***************************************
  // receive buffer and errors
  // ***************************************
  wire       io_rx    = io_last & mode_q.receive_enable;
  wire       rx_take  = (rx_xfer & wake_ok) | io_rx; // RULE_10
  wire [8:0] rx_word  = uart ? u_word : {1'b0, pins_s.rxd, rx_sh_q[8:2]};
  wire       rx_dpar  = m8 ? ^rx_word[7:0] : ^rx_word[6:0];
  wire       rx_pbit  = m8 ? rx_word[8] : rx_word[7];
  wire       ovr_set  = rx_take & buf_full_q; // RULE_04
  wire       parity_error_flag_set = rx_xfer & par_on & (rx_pbit != (rx_dpar ^ ~even_q)); // RULE_03
  wire       framing_error_flag_set = centre & (rx_st_q == RX_STOP) & ~maj; // RULE_02

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_buf_q   <= 8'h00;
      rb8_q      <= 1'b0;
      buf_full_q <= 1'b0;
      err_q      <= 3'h0;
    end else begin
      if (rd_cap && hit_buf) buf_full_q <= 1'b0;
      if (rx_take && !buf_full_q) begin
        rx_buf_q   <= rx_word[7:0];
        buf_full_q <= 1'b1;
        if (uart && nb == 4'h9) rb8_q <= rx_word[8];
      end
      err_q <= (err_q & ~{3{rd_cap & hit_ctl}}) | {ovr_set, parity_error_flag_set, framing_error_flag_set}; // RULE_17
    end
  end

  // ***************************************
  // transmitter
  // ***************************************
  scec_tx_st_t tx_st_q;
  logic [3:0]  tx_div_q;
  logic [3:0]  tx_bit_q;
  logic [8:0]  tx_sh_q;
  logic        txd_q;
  wire         tx_tick  = smp_tick & (tx_div_q == `SCEC_TX_DIV);
  wire         tx_par   = (m8 ? ^tx_buf_q : ^tx_buf_q[6:0]) ^ ~even_q;
  wire         cts_hold = mode_q.handshake_enable & pins_s.cts_n;
  // RULE_16
  wire         tx_go    = uart & tx_tick & (tx_st_q == TX_IDLE) & tx_full_q & ~cts_hold;
  wire [8:0]   tx_frame = m9 ? {mode_q.tx_ninth_bit, tx_buf_q} :
                          m8 ? {par_on & tx_par, tx_buf_q} :
                          {1'b0, par_on & tx_par, tx_buf_q[6:0]};
  // RULE_07
  wire         tx_uevt  = uart & tx_tick & (tx_st_q == TX_DATA) & (tx_bit_q == nb);
  wire         tx_evt   = tx_uevt | (io_last & io_tx_q); // RULE_08 RULE_09

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tx_st_q  <= TX_IDLE;
      tx_div_q <= 4'h0;
      tx_bit_q <= 4'h0;
      tx_sh_q  <= 9'h000;
      txd_q    <= 1'b1;
    end else if (!uart) begin
      tx_st_q <= TX_IDLE;
      if (io_go && tx_full_q) begin
        tx_sh_q <= {1'b0, tx_buf_q};
        txd_q   <= tx_buf_q[0];
      end else if (io_act && io_tx_q) begin
        tx_sh_q <= tx_sh_q >> 1;
        txd_q   <= io_last | tx_sh_q[1];
      end
    end else begin
      if (smp_tick) tx_div_q <= tx_div_q + 4'h1;
      if (tx_tick) begin
        case (tx_st_q)
          TX_IDLE: if (tx_go) begin
            tx_st_q <= TX_START;
            tx_sh_q <= tx_frame;
            txd_q   <= 1'b0;
          end
          TX_START: begin
            tx_st_q  <= TX_DATA;
            txd_q    <= tx_sh_q[0];
            tx_sh_q  <= tx_sh_q >> 1;
            tx_bit_q <= 4'h1;
          end
          TX_DATA: if (tx_bit_q == nb) begin
            tx_st_q <= TX_STOP;
            txd_q   <= 1'b1;
          end else begin
            txd_q    <= tx_sh_q[0];
            tx_sh_q  <= tx_sh_q >> 1;
            tx_bit_q <= tx_bit_q + 4'h1;
          end
          TX_STOP: tx_st_q <= TX_IDLE;
          default: tx_st_q <= TX_IDLE;
        endcase
      end
    end
  end

  // ***************************************
  // software registers and interrupts
  // ***************************************
  wire [4:0] ev    = {framing_error_flag_set, parity_error_flag_set, ovr_set, tx_evt, rx_take};
  wire [4:0] w1c   = (wr0 & hit_ist) ? writedata_i[4:0] : 5'h00;
  wire [7:0] rd8   = hit_buf ? rx_buf_q : hit_ctl ? ctl_rd : hit_mod ? mode_q :
                     hit_ist ? {3'h0, ist_q} : hit_imsk ? {3'h0, imsk_q} : 8'h00;
  wire [15:0] rd16 = hit_div ? 16'(div_q) : {8'h00, rd8};

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_q      <= 1'b0;
      readdata_o <= 32'h0000_0000;
      mode_q     <= `SCEC_MOD_RST;
      {even_q, pe_q, sclks_q, ioc_q} <= 4'h0;
      div_q      <= DIV_W'(`SCEC_DIV_RST);
      tx_buf_q   <= 8'h00;
      tx_full_q  <= 1'b0;
      ist_q      <= 5'h00;
      imsk_q     <= 5'h00;
      irq_o      <= 1'b0;
      receive_interrupt_o  <= 1'b0;
      transmit_interrupt_o <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
      if (rd_cap) readdata_o <= {16'h0000, rd16};
      if (wr0 && hit_mod) mode_q <= writedata_i[7:0];
      if (wr0 && hit_ctl) begin
        ioc_q   <= writedata_i[`SCEC_CTL_IOC];
        sclks_q <= writedata_i[`SCEC_CTL_SCLKS];
        pe_q    <= writedata_i[`SCEC_CTL_PE];
        even_q  <= writedata_i[`SCEC_CTL_EVEN];
      end
      if (wr0 && hit_div) div_q[7:0] <= writedata_i[7:0];
      if (wr1 && hit_div) div_q[DIV_W-1:8] <= writedata_i[DIV_W-1:8];
      if (wr0 && hit_imsk) imsk_q <= writedata_i[4:0];
      if (tx_go || (io_go && tx_full_q)) tx_full_q <= 1'b0;
      if (wr0 && hit_buf) begin
        tx_buf_q  <= writedata_i[7:0];
        tx_full_q <= 1'b1;
      end
      ist_q <= (ist_q & ~w1c) | ev;
      irq_o <= |(ist_q & imsk_q);
      receive_interrupt_o  <= rx_take;
      transmit_interrupt_o <= tx_evt;
    end
  end

  assign txd_o                 = txd_q;
  assign serial_clock_pin_o    = sclk_q;
  assign serial_clock_pin_oe_o = ~uart & ~ioc_q; // RULE_11

  // ***************************************
  // assertions
  // ***************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_hold;
    cts_hold && uart && tx_st_q == TX_IDLE;
  endsequence
  property p_rx_point;
    rx_xfer |-> rx_cnt_q == 4'h8 && (early ? rx_st_q == RX_DATA : rx_st_q == RX_STOP);
  endproperty
  a_rx_point: assert property (p_rx_point) else $error("rx event off frame point"); // RULE_01
  property p_framing_error_flag;
    framing_error_flag_set |=> err_q[0] && $past(rx_st_q) == RX_STOP;
  endproperty
  a_framing_error_flag: assert property (p_framing_error_flag) else $error("framing error misplaced"); // RULE_02
  property p_parity_error_flag;
    parity_error_flag_set |-> !m9 && pe_q;
  endproperty
  a_parity_error_flag: assert property (p_parity_error_flag) else $error("parity error in 9-bit mode"); // RULE_03
  property p_ovr;
    ovr_set |=> err_q[2] && $stable(rx_buf_q) && ist_q[`SCEC_IRQ_OVR];
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun lost or buffer overwritten"); // RULE_04
  property p_tx_stop;
    tx_uevt |=> tx_st_q == TX_STOP && txd_o ##[1:300] tx_st_q == TX_IDLE;
  endproperty
  a_tx_stop: assert property (p_tx_stop) else $error("tx irq not before stop"); // RULE_07
  property p_io_tx;
    io_last && io_tx_q |=> !io_run_q && transmit_interrupt_o;
  endproperty
  a_io_tx: assert property (p_io_tx) else $error("io tx irq late"); // RULE_08
  property p_io_rx;
    io_rx && !buf_full_q |=> buf_full_q && receive_interrupt_o;
  endproperty
  a_io_rx: assert property (p_io_rx) else $error("io rx byte not buffered"); // RULE_10
  property p_maj;
    centre && rx_st_q == RX_START && smp_q == 2'h0 |=> rx_st_q == RX_DATA;
  endproperty
  a_maj: assert property (p_maj) else $error("start bit majority ignored"); // RULE_14
  property p_wake;
    rx_take && uart && mode_q.wakeup_enable && m9 |-> rx_word[8];
  endproperty
  a_wake: assert property (p_wake) else $error("wakeup irq with bit8 clear"); // RULE_15
  property p_cts;
    s_hold |=> tx_st_q == TX_IDLE;
  endproperty
  a_cts: assert property (p_cts) else $error("frame started while held"); // RULE_16
  property p_rd_clr;
    rd_cap && hit_ctl && ev[4:2] == 3'h0 |=> err_q == 3'h0;
  endproperty
  a_rd_clr: assert property (p_rd_clr) else $error("control read kept errors"); // RULE_17
endmodule

// File: scec_remote.sv
// remote serial device model: frame sender and frame capture
`timescale 1ns/1ns
module scec_remote #(
  parameter int BIT_CLKS = 16
) (
  // clock
  input  wire logic clk_i,
  // serial lines
  input  wire logic line_i,
  output logic      line_o
);
  logic [10:0] got;
  int          nrx = 10;
  initial line_o = 1'b1;
  // ****
  // sender, line idles high like a pulled-up wire
  // ****
  task automatic send(input logic [10:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      line_o <= f[i];
      repeat (BIT_CLKS) @(posedge clk_i);
    end
    line_o <= 1'b1;
  endtask
  // ****
  // capture at bit centres
  // ****
  always begin
    @(negedge line_i);
    repeat (BIT_CLKS / 2) @(posedge clk_i);
    for (int i = 0; i < nrx; i++) begin
      got[i] = line_i;
      repeat (BIT_CLKS) @(posedge clk_i);
    end
  end
endmodule

// File: serial_channel_event_timing_test.sv
// bench for the serial channel event timing block
`timescale 1ns/1ns
`include "scec_map.svh"
module serial_channel_event_timing_test;
  import scec_pkg::*;
  logic        clk_i = 1'b0, rstn_i = 1'b0, rdr = 1'b0, wrr = 1'b0, io_sel = 1'b0;
  logic        io_rxd = 1'b1, sclk = 1'b1, cts_n = 1'b0, bp, bs;
  logic        wreq, txd, remote_tx, rx_p, tx_p, irq, oe;
  wire         rxd = io_sel ? io_rxd : remote_tx;
  logic [15:0] adr = 16'h0;
  logic [31:0] wd = 32'h0, rdata, rd, d;
  logic [8:0]  pay;
  int          miscompares = 0, check_count = 0, cyc = 0, rx_at = 0, tx_at = 0;
  int          falls = 0, seed = 31, t0, nb, pe, k;
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (rx_p === 1'b1) rx_at <= cyc;
    if (tx_p === 1'b1) tx_at <= cyc;
  end
  always @(negedge txd) falls++;
  scec_top scec_top_i (.clk_i(clk_i), .rstn_i(rstn_i), .address_i(adr), .read_i(rdr),
    .write_i(wrr), .writedata_i(wd), .byteenable_i(4'hf), .readdata_o(rdata),
    .waitrequest_o(wreq), .rxd_i(rxd), .txd_o(txd), .serial_clock_pin_i(sclk),
    .serial_clock_pin_o(), .serial_clock_pin_oe_o(oe), .clear_to_send_input_n_i(cts_n),
    .timer_a0_trig_i(1'b0), .receive_interrupt_o(rx_p), .transmit_interrupt_o(tx_p),
    .irq_o(irq));
  scec_remote scec_remote_i (.clk_i(clk_i), .line_i(txd), .line_o(remote_tx));
  // ****
  // shared tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] e, input string s);
    check_count++;
    if (got !== e) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, s, got, e);
    end
  endtask
  task automatic bus(input logic w, input logic [13:0] idx, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk_i);
    adr <= {idx, 2'b00};
    wd <= v;
    wrr <= w;
    rdr <= ~w;
    do begin
      @(posedge clk_i);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    rd = rdata;
    rdr <= 1'b0;
    wrr <= 1'b0;
    if (n >= 50) chk(0, 1, "bus hang");
  endtask
  task automatic rdchk(input logic [13:0] idx, input logic [31:0] e, input string s);
    bus(0, idx, 0);
    chk(rd, e, s);
  endtask
  // frame start at t0; event window from the bit centre, later at speed
  task automatic rx_frame(input int n, input logic [8:0] p, input logic bad, input logic ex);
    logic [10:0] f;
    int          ev;
    int          was;
    f = {2'b0, p} << 1;
    f[n+1] = ~bad;
    ev = (n == 9) ? 9 : n + 1;
    was = rx_at;
    @(posedge clk_i);
    t0 = cyc;
    scec_remote_i.send(f, n + 2);
    repeat (16) @(posedge clk_i);
    if (ex) chk(32'(rx_at - t0 >= ev * 16 + 8 && rx_at - t0 <= ev * 16 + 16), 1, "rx time");
    else chk(rx_at, was, "wake drop");
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk_i);
    miscompares++;
    results;
  end
  // ****
  // main sequence
  // ****
  initial begin
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rdchk(`SCEC_IDX_MOD, {24'h0, `SCEC_MOD_RST}, "mode reset");
    d = $random(seed) & 32'hdf;
    bus(1, `SCEC_IDX_MOD, d);
    rdchk(`SCEC_IDX_MOD, d, "mode readback");
    bus(1, 14'h1210, 32'hff);
    rdchk(14'h1210, 0, "unmapped");
    $display("test registers done");
    for (int c = 0; c < 5; c++) begin
      nb = 7 + (c + 1) / 2;
      pe = c % 2;
      bus(1, `SCEC_IDX_MOD, 32'h22 | ((c / 2 + 1) << 2));
      bus(1, `SCEC_IDX_CTL, pe ? 32'h60 : 32'h0);
      d = $random(seed);
      bp = pe && ($random(seed) & 1);
      bs = $random(seed) & 1;
      pay = d[8:0] & ((9'h1 << (nb - pe)) - 9'h1);
      if (pe) pay[nb-1] = ^pay ^ bp;
      rx_frame(nb, pay, bs, 1);
      rdchk(`SCEC_IDX_IST, {27'h0, bs, bp, 3'h1}, "status");
      rdchk(`SCEC_IDX_BUF, {24'h0, pay[7:0] & (nb == 7 ? 8'h7f : 8'hff)}, "rx data");
      bus(1, `SCEC_IDX_IMSK, 32'h0);
      repeat (2) @(posedge clk_i);
      chk(irq, 0, "masked irq");
      bus(1, `SCEC_IDX_IMSK, 32'h1);
      repeat (2) @(posedge clk_i);
      chk(irq, 1, "irq");
      bus(1, `SCEC_IDX_IST, 32'h1f);
      rdchk(`SCEC_IDX_IST, 0, "status cleared");
      chk(irq, 0, "irq cleared");
      bus(0, `SCEC_IDX_CTL, 0);
      chk(rd[4:2], {1'b0, bp, bs}, "ctl errors");
      bus(0, `SCEC_IDX_CTL, 0);
      chk(rd[4:2], 3'h0, "errors cleared by read");
    end
    $display("test rx modes done");
    bus(1, `SCEC_IDX_MOD, 32'h2a);
    bus(1, `SCEC_IDX_CTL, 32'h0);
    d = $random(seed);
    rx_frame(8, {1'b0, d[7:0]}, 0, 1);
    rx_frame(8, {1'b0, ~d[7:0]}, 0, 1);
    rdchk(`SCEC_IDX_IST, 32'h5, "overrun status");
    rdchk(`SCEC_IDX_BUF, {24'h0, d[7:0]}, "kept data");
    bus(1, `SCEC_IDX_IST, 32'h1f);
    bus(1, `SCEC_IDX_MOD, 32'h3e);
    rx_frame(9, {1'b0, d[7:0]}, 0, 0);
    rx_frame(9, {1'b1, d[7:0]}, 0, 1);
    rdchk(`SCEC_IDX_BUF, {24'h0, d[7:0]}, "wake data");
    bus(1, `SCEC_IDX_IST, 32'h1f);
    $display("test overrun and wake done");
    bus(1, `SCEC_IDX_MOD, 32'h6a);
    cts_n <= 1'b1;
    repeat (4) @(posedge clk_i);
    k = falls;
    bus(1, `SCEC_IDX_BUF, d);
    repeat (300) @(posedge clk_i);
    chk(falls, k, "held by handshake");
    cts_n <= 1'b0;
    for (int n = 0; n < 400 && falls == k; n++) @(posedge clk_i);
    t0 = cyc;
    repeat (200) @(posedge clk_i);
    chk(32'(tx_at - t0 >= 136 && tx_at - t0 <= 144), 1, "tx time");
    chk(scec_remote_i.got[9:0], {1'b1, d[7:0], 1'b0}, "tx frame");
    $display("test tx done");
    // external shift clock at 800 ns, rising then falling active edge
    for (int s = 0; s < 2; s++) begin
      // receive stays off until the tx byte is loaded, so one run carries both
      bus(1, `SCEC_IDX_MOD, $random(seed) & 3);
      bus(1, `SCEC_IDX_CTL, s ? 32'h3 : 32'h1);
      d = $random(seed);
      bus(1, `SCEC_IDX_BUF, d);
      chk(oe, 0, "clock from control reg");
      bus(1, `SCEC_IDX_MOD, 32'h20 | ($random(seed) & 3));
      io_sel <= 1'b1;
      io_rxd <= d[0];
      for (int i = 0; i < 8; i++) begin
        sclk <= 1'b0;
        if (s) t0 = cyc;
        repeat (4) @(posedge clk_i);
        pay[i] = txd;
        sclk <= 1'b1;
        if (!s) t0 = cyc;
        repeat (2) @(posedge clk_i);
        io_rxd <= d[i+1];
        repeat (2) @(posedge clk_i);
      end
      repeat (4) @(posedge clk_i);
      chk(32'(rx_at - t0 >= 1 && rx_at - t0 <= 8), 1, "io rx time");
      chk(32'(tx_at - t0 >= 1 && tx_at - t0 <= 8), 1, "io tx time");
      chk(pay[7:0], d[7:0], "io tx data");
      bus(1, `SCEC_IDX_MOD, 32'h0);
      rdchk(`SCEC_IDX_BUF, {24'h0, d[7:0]}, "io data");
      io_sel <= 1'b0;
    end
    $display("test io done");
    results;
  end
endmodule
